// *** hdl/drcpc_rank_cke_ctrl.sv ***
// Per-rank clock-enable power control for one memory channel, with AHB-Lite registers.
// Assumes the command queue sits on hclk and that mem_clk arrives asynchronously, far slower than hclk.
`timescale 1ns/10ps
`default_nettype none

module drcpc_rank_cke_ctrl
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        mem_clk,
	input  wire logic [3:0]  rank_txn_arrive,
	input  wire logic [3:0]  rank_queue_pending,
	input  wire logic [3:0]  rank_cmd_req,
	output logic [3:0]       rank_cmd_ready,
	input  wire logic [3:0]  rank_pages_open,
	output logic [3:0]       rank_close_pages,
	input  wire logic        refresh_pending,
	output logic             refresh_grant,
	input  wire logic        pkg_deep_cstate,
	input  wire logic        sleep_s3,
	input  wire logic        sleep_s4,
	input  wire logic        mem_requests_pending,
	input  wire logic        gfx_in_use,
	input  wire logic        gfx_idle,
	input  wire logic        display_pending,
	input  wire logic [3:0]  gfx_rank_mask,
	output logic             drain_req,
	output logic [3:0]       sref_enter,
	output logic [3:0]       sref_exit,
	output logic [3:0]       cke,
	output logic [3:0]       cke_oe,
	output logic [3:0]       rank_io_en,
	output logic             dram_dll_off
);

	// ================================================================
	// Registers and bus slave
	logic [15:0] dram_powerdown_config;
	logic [8:0]  control;
	logic        cfg_written;
	logic        wr_pend;
	logic [7:0]  wr_addr;
	logic        addr_phase;
	logic [31:0] status;
	logic [3:0]  pd_type;
	logic [11:0] idle_limit;
	logic        locked;

	drcpc_pkg::drcpc_rank_state_e state [drcpc_pkg::RANKS];

	assign pd_type = dram_powerdown_config[drcpc_pkg::TYPE_MSB:drcpc_pkg::TYPE_LSB];
	assign idle_limit = dram_powerdown_config[drcpc_pkg::LIMIT_MSB:drcpc_pkg::LIMIT_LSB];
	assign locked = control[drcpc_pkg::CTL_LOCK_BIT];
	assign dram_dll_off = (pd_type == drcpc_pkg::TYPE_DLL_OFF);
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign addr_phase = hsel & hready & (htrans == drcpc_pkg::HTRANS_NONSEQ);

	// ================================================================
	// Write strobes, qualified in the data phase where hwdata stands
	logic wr_config;
	logic wr_control;
	logic rd_take;

	// A locked config write is dropped silently; the bus still answers OKAY
	assign wr_config = wr_pend & (wr_addr == drcpc_pkg::ADDR_CONFIG) & ~locked;
	assign wr_control = wr_pend & (wr_addr == drcpc_pkg::ADDR_CONTROL);
	// Read data is latched in the address phase, so a read right behind a write sees the old word
	assign rd_take = addr_phase & ~hwrite;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end
		else
		begin
			wr_pend <= addr_phase & hwrite;
			wr_addr <= haddr[7:0];
		end
	end

	// Lock only guards the config word; the lock bit itself stays set until reset
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dram_powerdown_config <= drcpc_pkg::CONFIG_RESET;
			cfg_written <= 1'b0;
		end
		else if (wr_config)
		begin
			dram_powerdown_config <= hwdata[15:0];
			cfg_written <= 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			control <= drcpc_pkg::CONTROL_RESET;
		else if (wr_control)
		begin
			control[drcpc_pkg::CTL_LOCK_BIT] <= locked | hwdata[drcpc_pkg::CTL_LOCK_BIT];
			control[8:1] <= hwdata[8:1];
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (rd_take)
		begin
			unique case (haddr[7:0])
				drcpc_pkg::ADDR_CONFIG:  hrdata <= {16'h0000, dram_powerdown_config};
				drcpc_pkg::ADDR_CONTROL: hrdata <= {23'h00_0000, control};
				drcpc_pkg::ADDR_STATUS:  hrdata <= status;
				default:                 hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// ================================================================
	// Memory clock edge finder; a rising level change counts as one memory cycle
	// The level is only trusted once the second and third stages agree, so a
	// metastable first stage can never make a double count; cost is 3-4 hclk of lag
	logic mclk_s1;
	logic mclk_s2;
	logic mclk_s3;
	logic mclk_lvl;
	logic mtick;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			mclk_s1 <= 1'b0;
			mclk_s2 <= 1'b0;
			mclk_s3 <= 1'b0;
			mclk_lvl <= 1'b0;
			mtick <= 1'b0;
		end
		else
		begin
			mclk_s1 <= mem_clk;
			mclk_s2 <= mclk_s1;
			mclk_s3 <= mclk_s2;
			if (mclk_s2 == mclk_s3)
				mclk_lvl <= mclk_s3;
			mtick <= (mclk_s2 == mclk_s3) & mclk_s3 & ~mclk_lvl;
		end
	end

	// ================================================================
	// Channel-wide self-refresh conditions
	logic gfx_ok;
	logic sr_go;
	logic sr_hold;
	logic [5:0] dll_extra;
	logic [3:0] rank_ready_all;

	assign gfx_ok = ~gfx_in_use | (gfx_idle & ~display_pending);
	assign drain_req = sleep_s3 | (pkg_deep_cstate & gfx_ok);
	assign sr_go = drain_req & ~mem_requests_pending & ~sleep_s4;
	assign sr_hold = sleep_s3 | sr_go;
	assign dll_extra = control[drcpc_pkg::CTL_LONG_DLL_BIT] ? drcpc_pkg::EXIT_DLL_LONG
		: drcpc_pkg::EXIT_DLL_SHORT;
	assign refresh_grant = refresh_pending & (&rank_ready_all);

	// ================================================================
	// Per-rank machines
	genvar r;
	generate
		for (r = 0; r < drcpc_pkg::RANKS; r = r + 1)
		begin : g_rank
			logic [11:0] idle_cnt;
			logic [5:0]  exit_cnt;
			logic        entry_dll_off;
			logic        after_refresh;
			logic        excl;
			logic        wake;
			logic        expired;
			logic        pd_allowed;
			logic        needs_close;
			logic [5:0]  exit_load;
			logic        absent;

			assign absent = control[drcpc_pkg::CTL_TRI_LSB + r];
			assign excl = gfx_in_use & gfx_rank_mask[r];
			assign wake = rank_txn_arrive[r] | rank_queue_pending[r] | rank_cmd_req[r]
				| refresh_pending | (pd_type == drcpc_pkg::TYPE_NONE);
			assign expired = (idle_cnt >= idle_limit);
			assign pd_allowed = (pd_type != drcpc_pkg::TYPE_NONE) & ~refresh_pending
				& ~rank_queue_pending[r] & ~rank_txn_arrive[r] & ~rank_cmd_req[r]
				& (expired | after_refresh);
			assign needs_close = rank_pages_open[r] & ((pd_type == drcpc_pkg::TYPE_PRECHARGED)
				| (pd_type == drcpc_pkg::TYPE_DLL_OFF));
			assign exit_load = entry_dll_off ? 6'(drcpc_pkg::EXIT_TXP + dll_extra)
				: drcpc_pkg::EXIT_TXP;

			// Idle count only runs while the rank is in RS_ACTIVE; it restarts on each arrival
			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
					idle_cnt <= drcpc_pkg::IDLE_ZERO;
				else if (rank_txn_arrive[r] || state[r] != drcpc_pkg::RS_ACTIVE)
					idle_cnt <= drcpc_pkg::IDLE_ZERO;
				else if (mtick && idle_cnt != drcpc_pkg::IDLE_MAX)
					idle_cnt <= idle_cnt + drcpc_pkg::IDLE_ONE;
			end

			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
					after_refresh <= 1'b0;
				else if (state[r] == drcpc_pkg::RS_PDOWN && refresh_pending)
					after_refresh <= 1'b1;
				else if (rank_txn_arrive[r] || state[r] == drcpc_pkg::RS_PDOWN)
					after_refresh <= 1'b0;
			end

			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
				begin
					state[r] <= drcpc_pkg::RS_OFF;
					exit_cnt <= drcpc_pkg::EXIT_ZERO;
					entry_dll_off <= 1'b0;
					sref_enter[r] <= 1'b0;
					sref_exit[r] <= 1'b0;
				end
				else
				begin
					sref_enter[r] <= 1'b0;
					sref_exit[r] <= 1'b0;
					unique case (state[r])
						drcpc_pkg::RS_OFF:
						begin
							if (!sleep_s4 && cfg_written)
							begin
								state[r] <= drcpc_pkg::RS_EXIT;
								exit_cnt <= drcpc_pkg::EXIT_TXP;
								entry_dll_off <= 1'b0;
							end
						end
						drcpc_pkg::RS_ACTIVE:
						begin
							if (sleep_s4)
								state[r] <= drcpc_pkg::RS_OFF;
							else if (sr_go && !excl && !refresh_pending)
							begin
								state[r] <= drcpc_pkg::RS_SREF;
								sref_enter[r] <= 1'b1;
							end
							else if (pd_allowed && needs_close)
								state[r] <= drcpc_pkg::RS_CLOSE;
							else if (pd_allowed)
							begin
								state[r] <= drcpc_pkg::RS_PDOWN;
								entry_dll_off <= dram_dll_off;
							end
						end
						drcpc_pkg::RS_CLOSE:
						begin
							if (sleep_s4)
								state[r] <= drcpc_pkg::RS_OFF;
							else if (wake)
								state[r] <= drcpc_pkg::RS_ACTIVE;
							else if (!rank_pages_open[r])
							begin
								state[r] <= drcpc_pkg::RS_PDOWN;
								entry_dll_off <= dram_dll_off;
							end
						end
						// Pages stay open here in active power-down; only CLOSE precharges them
						drcpc_pkg::RS_PDOWN:
						begin
							if (sleep_s4)
								state[r] <= drcpc_pkg::RS_OFF;
							else if (wake || (sr_go && !excl))
							begin
								state[r] <= drcpc_pkg::RS_EXIT;
								exit_cnt <= exit_load;
							end
						end
						drcpc_pkg::RS_EXIT:
						begin
							if (sleep_s4)
								state[r] <= drcpc_pkg::RS_OFF;
							else if (exit_cnt == drcpc_pkg::EXIT_ZERO)
								state[r] <= drcpc_pkg::RS_ACTIVE;
							else if (mtick)
								exit_cnt <= exit_cnt - drcpc_pkg::EXIT_ONE;
						end
						// The rank refreshes itself; clock-enable stays low until the sleep request ends
						drcpc_pkg::RS_SREF:
						begin
							if (sleep_s4)
								state[r] <= drcpc_pkg::RS_OFF;
							else if (!sr_hold)
							begin
								state[r] <= drcpc_pkg::RS_EXIT;
								exit_cnt <= drcpc_pkg::EXIT_TXP;
								entry_dll_off <= 1'b0;
								sref_exit[r] <= 1'b1;
							end
						end
						default:
							state[r] <= drcpc_pkg::RS_OFF;
					endcase
				end
			end

			// Clock-enable is high only in states where the rank is awake or waking
			assign cke[r] = (state[r] == drcpc_pkg::RS_ACTIVE) | (state[r] == drcpc_pkg::RS_CLOSE)
				| (state[r] == drcpc_pkg::RS_EXIT);
			// Tri-stating clock-enable on a populated rank risks data, so only on software say-so
			assign cke_oe[r] = ~absent;
			assign rank_io_en[r] = ~absent;
			assign rank_cmd_ready[r] = (state[r] == drcpc_pkg::RS_ACTIVE) & ~absent;
			assign rank_close_pages[r] = (state[r] == drcpc_pkg::RS_CLOSE);
			assign rank_ready_all[r] = absent | (state[r] == drcpc_pkg::RS_ACTIVE);
			assign status[drcpc_pkg::ST_PDOWN_LSB + r] = (state[r] == drcpc_pkg::RS_PDOWN);
			assign status[drcpc_pkg::ST_SREF_LSB + r] = (state[r] == drcpc_pkg::RS_SREF);
			assign status[drcpc_pkg::ST_CLOSE_LSB + r] = (state[r] == drcpc_pkg::RS_CLOSE);
		end
	endgenerate

	// ================================================================
	// Status word; unused bits read zero
	assign status[3:0] = cke;
	assign status[drcpc_pkg::ST_CFG_BIT] = cfg_written;
	assign status[drcpc_pkg::ST_LOCK_BIT] = locked;
	assign status[15:14] = 2'h0;
	assign status[31:20] = 12'h000;

endmodule

`default_nettype wire

// *** hdl/drcpc_pkg.sv ***
// Constants, register map and state codes for the per-rank clock-enable power control block.
// Assumes a single memory channel of four ranks, 32-bit AHB-Lite register access.
`default_nettype none

package drcpc_pkg;

	// ================================================================
	// Structure
	localparam int unsigned RANKS = 4;
	localparam int unsigned LIMIT_W = 12;
	localparam int unsigned EXIT_W = 6;

	// ================================================================
	// Register map (byte addresses, low byte of haddr decoded)
	localparam logic [7:0] ADDR_CONFIG = 8'h00;
	localparam logic [7:0] ADDR_CONTROL = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;

	// dram_powerdown_config fields
	localparam int unsigned TYPE_MSB = 15;
	localparam int unsigned TYPE_LSB = 12;
	localparam int unsigned LIMIT_MSB = 11;
	localparam int unsigned LIMIT_LSB = 0;
	localparam logic [15:0] CONFIG_RESET = 16'h0000;

	// Power-down type codes
	localparam logic [3:0] TYPE_NONE = 4'h0;
	localparam logic [3:0] TYPE_ACTIVE = 4'h1;
	localparam logic [3:0] TYPE_PRECHARGED = 4'h2;
	localparam logic [3:0] TYPE_DLL_OFF = 4'h6;

	// Control register fields
	localparam int unsigned CTL_LOCK_BIT = 0;
	localparam int unsigned CTL_TRI_LSB = 4;
	localparam int unsigned CTL_TRI_MSB = 7;
	localparam int unsigned CTL_LONG_DLL_BIT = 8;
	localparam logic [8:0] CONTROL_RESET = 9'h000;

	// Status register fields
	localparam int unsigned ST_CKE_LSB = 0;
	localparam int unsigned ST_PDOWN_LSB = 4;
	localparam int unsigned ST_SREF_LSB = 8;
	localparam int unsigned ST_CFG_BIT = 12;
	localparam int unsigned ST_LOCK_BIT = 13;
	localparam int unsigned ST_CLOSE_LSB = 16;

	// ================================================================
	// Exit delays in memory clock cycles
	localparam logic [5:0] EXIT_TXP = 6'h04;
	localparam logic [5:0] EXIT_DLL_SHORT = 6'h0a;
	localparam logic [5:0] EXIT_DLL_LONG = 6'h14;
	localparam logic [5:0] EXIT_ZERO = 6'h00;
	localparam logic [5:0] EXIT_ONE = 6'h01;
	localparam logic [11:0] IDLE_ZERO = 12'h000;
	localparam logic [11:0] IDLE_ONE = 12'h001;
	localparam logic [11:0] IDLE_MAX = 12'hfff;

	// AHB-Lite
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	// ================================================================
	// Per-rank state, one-hot
	typedef enum logic [5:0] {
		RS_OFF    = 6'b00_0001,
		RS_ACTIVE = 6'b00_0010,
		RS_CLOSE  = 6'b00_0100,
		RS_PDOWN  = 6'b00_1000,
		RS_EXIT   = 6'b01_0000,
		RS_SREF   = 6'b10_0000
	} drcpc_rank_state_e;

endpackage

`default_nettype wire

// *** test/drcpc_sva.sv ***
// Concurrent checks on the ports of the rank clock-enable power control block.
// Assumes one hclk domain with the asynchronous active-low hresetn; bound to every instance of the top.
`timescale 1ns/10ps
`default_nettype none

module drcpc_sva
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [3:0]  rank_txn_arrive,
	input wire logic [3:0]  rank_queue_pending,
	input wire logic [3:0]  rank_cmd_ready,
	input wire logic [3:0]  rank_close_pages,
	input wire logic        refresh_grant,
	input wire logic        pkg_deep_cstate,
	input wire logic        sleep_s3,
	input wire logic        sleep_s4,
	input wire logic [3:0]  sref_enter,
	input wire logic [3:0]  cke,
	input wire logic [3:0]  cke_oe,
	input wire logic [3:0]  rank_io_en
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// ================================================================
	// Helper: has the config register seen a write since reset
	logic cfg_wr_phase;
	logic cfg_seen;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cfg_wr_phase <= 1'b0;
			cfg_seen     <= 1'b0;
		end
		else
		begin
			cfg_wr_phase <= hsel & hready & (htrans == drcpc_pkg::HTRANS_NONSEQ) & hwrite
				& (haddr[7:0] == drcpc_pkg::ADDR_CONFIG);
			if (cfg_wr_phase)
				cfg_seen <= 1'b1;
		end
	end

	// ================================================================
	// Sequences
	sequence s_rank0_wake;
		$rose(cke[0]);
	endsequence

	sequence s_s4_held;
		sleep_s4 [*3];
	endsequence

	// ================================================================
	// Assertions
	a_cke_until_cfg: assert property (!cfg_seen |-> cke == 4'h0)
		else $error("clock-enable high before the config write");
	a_ready_cke: assert property ((rank_cmd_ready & ~cke) == 4'h0)
		else $error("command ready on a rank whose clock-enable is low");
	a_exit_wait: assert property (s_rank0_wake |-> !rank_cmd_ready[0] [*8])
		else $error("rank 0 ready too soon after waking");
	a_fall_idle: assert property (!$past(sleep_s4) |-> ($past(cke) & ~cke & $past(rank_queue_pending | rank_txn_arrive)) == 4'h0)
		else $error("clock-enable dropped with work queued");
	a_close_cke: assert property (rank_close_pages != 4'h0 |-> (rank_close_pages & ~cke) == 4'h0)
		else $error("pages closing on a powered-down rank");
	a_grant_awake: assert property (refresh_grant |-> (cke & cke_oe) == cke_oe)
		else $error("refresh granted while a present rank sleeps");
	a_sref_low: assert property (sref_enter != 4'h0 |=> (cke & $past(sref_enter)) == 4'h0)
		else $error("clock-enable high after self-refresh entry");
	a_shallow_nosref: assert property ((!pkg_deep_cstate && !sleep_s3) [*3] |-> sref_enter == 4'h0)
		else $error("self-refresh entry in a shallow package state");
	a_s4_off: assert property (s_s4_held |-> cke == 4'h0)
		else $error("clock-enable high in S4");
	a_oe_io_pair: assert property (cke_oe == rank_io_en)
		else $error("rank drivers and clock-enable enable disagree");
endmodule

bind drcpc_rank_cke_ctrl drcpc_sva chk (.*);

`default_nettype wire

// *** test/drcpc_rank_model.sv ***
// Behavioural model of the DRAM ranks: tracks open pages per rank.
// Assumes the block's hclk; the precharge takes 2 cycles, or 8 with slow set.
`timescale 1ns/10ps
`default_nettype none

module drcpc_rank_model
(
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       slow,
	input  wire logic [3:0] rank_txn_arrive,
	input  wire logic [3:0] rank_close_pages,
	output logic [3:0]      rank_pages_open
);
	logic [3:0] age [4];

	// ================================================================
	// Pages open on traffic, stay open through power-down, close on precharge
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rank_pages_open <= 4'h0;
			for (int i = 0; i < 4; i++)
				age[i] <= 4'h0;
		end
		else
		begin
			for (int i = 0; i < 4; i++)
			begin
				age[i] <= rank_close_pages[i] ? age[i] + 4'h1 : 4'h0;
				if (rank_txn_arrive[i])
					rank_pages_open[i] <= 1'b1;
				else if (rank_close_pages[i] && age[i] >= (slow ? 4'h7 : 4'h1))
					rank_pages_open[i] <= 1'b0;
			end
		end
	end
endmodule

`default_nettype wire

// *** test/tb.sv ***
// Self-checking bench for the rank clock-enable power control block.
// Assumes the design and rank model share the bench's signal names; memory clock free-running.
`timescale 1ns/10ps
`default_nettype none

module tb;
	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, mem_clk, slow;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [3:0]  rank_txn_arrive, rank_queue_pending, rank_cmd_req, rank_cmd_ready, rank_pages_open;
	logic [3:0]  rank_close_pages, gfx_rank_mask, sref_enter, sref_exit, cke, cke_oe, rank_io_en;
	logic        refresh_pending, refresh_grant, pkg_deep_cstate, sleep_s3, sleep_s4;
	logic        mem_requests_pending, gfx_in_use, gfx_idle, display_pending, drain_req, dram_dll_off;
	logic [7:0]  steps [7];
	int          miscompares, compares, k;

	assign hready = hreadyout;

	drcpc_rank_cke_ctrl dut (.*);
	drcpc_rank_model partner (.*);

	always #4 hclk = ~hclk;
	always #62.5 mem_clk = ~mem_clk;

	// ================================================================
	// Shared tasks
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		compares++;
		if (s !== e)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask

	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0000_00, a};
		htrans <= drcpc_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		@(posedge hclk);
		for (k = 0; k < 16 && hreadyout !== 1'b1; k++) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		for (k = 0; k < 16 && hreadyout !== 1'b1; k++) @(posedge hclk);
		r = hrdata;
		hsel <= 1'b0;
	endtask

	task mem(input int n);
		repeat (n) @(posedge mem_clk);
		@(negedge hclk);
	endtask

	task arrive(input logic [3:0] m);
		@(posedge hclk);
		rank_txn_arrive <= m;
		@(posedge hclk);
		rank_txn_arrive <= 4'h0;
	endtask

	// ================================================================
	// Scenarios
	task t_reset;
		@(negedge hclk);
		chk("cke", 4'h0, cke);
		chk("cke_oe", 4'hf, cke_oe);
		mem(20);
		chk("cke", 4'h0, cke);
		ahb(1'b0, drcpc_pkg::ADDR_CONFIG, 32'h0000_0000);
		chk("config", 32'h0000_0000, r);
		$display("test reset done");
	endtask

	task t_dll_off;
		ahb(1'b1, drcpc_pkg::ADDR_CONFIG, 32'h0000_6080);
		ahb(1'b0, drcpc_pkg::ADDR_CONFIG, 32'h0000_0000);
		chk("config", 32'h0000_6080, r);
		for (k = 0; k < 2000 && rank_cmd_ready !== 4'hf; k++) @(negedge hclk);
		chk("ready", 4'hf, rank_cmd_ready);
		chk("dll_off", 1'b1, dram_dll_off);
		mem(110);
		chk("cke", 4'hf, cke);
		mem(30);
		chk("cke", 4'h0, cke);
		arrive(4'h1);
		mem(12);
		chk("cke", 4'h1, cke);
		chk("ready", 4'h0, rank_cmd_ready);
		mem(10);
		chk("ready", 4'h1, rank_cmd_ready);
		$display("test dll-off done");
	endtask

	task t_active;
		@(posedge hclk);
		rank_queue_pending <= 4'h2;
		rank_cmd_req <= 4'h4;
		ahb(1'b1, drcpc_pkg::ADDR_CONFIG, 32'h0000_1004);
		mem(30);
		chk("cke", 4'h6, cke);
		chk("pages", 4'h1, rank_pages_open);
		chk("close", 4'h0, rank_close_pages);
		chk("dll_off", 1'b0, dram_dll_off);
		@(posedge hclk);
		rank_queue_pending <= 4'h0;
		rank_cmd_req <= 4'h0;
		slow <= 1'b1;
		ahb(1'b1, drcpc_pkg::ADDR_CONFIG, 32'h0000_2004);
		arrive(4'h8);
		mem(40);
		chk("cke", 4'h0, cke);
		chk("pages", 4'h1, rank_pages_open);
		ahb(1'b1, drcpc_pkg::ADDR_CONFIG, 32'h0000_0001);
		mem(30);
		chk("cke", 4'hf, cke);
		$display("test idle power-down done");
	endtask

	task t_refresh;
		ahb(1'b1, drcpc_pkg::ADDR_CONFIG, 32'h0000_1001);
		mem(20);
		chk("cke", 4'h0, cke);
		@(posedge hclk);
		refresh_pending <= 1'b1;
		for (k = 0; k < 2000 && refresh_grant !== 1'b1; k++) @(negedge hclk);
		chk("grant", 1'b1, refresh_grant);
		chk("cke", 4'hf, cke);
		@(posedge hclk);
		refresh_pending <= 1'b0;
		mem(4);
		chk("cke", 4'h0, cke);
		$display("test refresh done");
	endtask

	task t_sleep;
		ahb(1'b1, drcpc_pkg::ADDR_CONFIG, 32'h0000_0000);
		mem(20);
		for (int i = 0; i < 7; i++)
		begin
			@(posedge hclk);
			{pkg_deep_cstate, sleep_s3, sleep_s4, mem_requests_pending} <= steps[i][7:4];
			mem(15);
			chk("cke", {28'h000_0000, steps[i][3:0]}, cke);
		end
		$display("test self-refresh done");
	endtask

	task t_regs;
		ahb(1'b1, drcpc_pkg::ADDR_CONTROL, 32'h0000_0020);
		@(negedge hclk);
		chk("cke_oe", 4'hd, cke_oe);
		chk("io_en", 4'hd, rank_io_en);
		ahb(1'b1, drcpc_pkg::ADDR_CONTROL, 32'h0000_0021);
		ahb(1'b1, drcpc_pkg::ADDR_CONFIG, 32'h0000_6080);
		ahb(1'b0, drcpc_pkg::ADDR_CONFIG, 32'h0000_0000);
		chk("config", 32'h0000_0000, r);
		ahb(1'b0, 8'h0c, 32'h0000_0000);
		chk("unmapped", 32'h0000_0000, r);
		ahb(1'b0, drcpc_pkg::ADDR_STATUS, 32'h0000_0000);
		chk("status", 32'h0000_300f, r);
		ahb(1'b1, drcpc_pkg::ADDR_CONTROL, 32'h0000_0000);
		ahb(1'b0, drcpc_pkg::ADDR_CONTROL, 32'h0000_0000);
		chk("control", 32'h0000_0001, r);
		chk("cke_oe", 4'hf, cke_oe);
		chk("hresp", 32'h0000_0000, {31'h0, hresp});
		$display("test registers done");
	endtask

	task final_report;
		$display("comparisons %0d mismatches %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ================================================================
	// Main sequence and watchdog
	initial
	begin
		{hclk, mem_clk, hresetn, hsel, hwrite, slow} = 6'h00;
		{haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
		{rank_txn_arrive, rank_queue_pending, rank_cmd_req, gfx_rank_mask} = 16'h0000;
		{refresh_pending, pkg_deep_cstate, sleep_s3, sleep_s4} = 4'h0;
		{mem_requests_pending, gfx_in_use, gfx_idle, display_pending} = 4'h0;
		steps = '{8'h9f, 8'h80, 8'h0f, 8'h20, 8'h0f, 8'h40, 8'h0f};
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_dll_off();
		t_active();
		t_refresh();
		t_sleep();
		t_regs();
		final_report();
	end

	initial
	begin
		#200_000;
		miscompares++;
		final_report();
	end
endmodule

`default_nettype wire
